// [hw/smc_backoff.sv]
// Back-off slot calculator: truncated binary exponential back-off with a cap per mode.
// Assumes collision requests arrive only from half-duplex ports.
`timescale 1ns/1ns
module smc_backoff (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	smc_bo_if.calc bo
);
	import smc_pkg::*;

	typedef struct packed {
		logic [15:0] lfsr;
		logic [9:0] slots;
		logic vld;
	} smc_bo_s;

	smc_bo_s s_q;
	smc_bo_s s_d;
	logic [3:0] kmax;
	logic [3:0] k;
	logic [9:0] mask;

	// ****************************************************************
	// Slot selection.
	// ****************************************************************

	// Aggressive mode wins over alternate because it gives the shorter cap.
	always_comb begin
		s_d = s_q;
		kmax = bo.aggr ? AGGR_KMAX : (bo.alt ? ALT_KMAX : STD_KMAX);
		k = (bo.coll_cnt > {1'b0, kmax}) ? kmax : bo.coll_cnt[3:0];
		mask = 10'((11'h001 << k) - 11'h001);
		s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};
		s_d.vld = bo.coll;
		if (bo.coll) begin
			s_d.slots = s_q.lfsr[9:0] & mask;
		end
	end

	// Free-running LFSR keeps successive draws decorrelated.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.lfsr <= LFSR_SEED;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign bo.vld = s_q.vld;
	assign bo.slots = s_q.slots;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	aggr_cap_a: assert property (ce && bo.coll && bo.aggr |=> s_q.slots < 10'h010)
		else $error("aggressive back-off exceeded its cap");
	alt_cap_a: assert property (ce && bo.coll && bo.alt && !bo.aggr |=> s_q.slots < 10'h100)
		else $error("alternate back-off exceeded its cap");
	cover_aggr_c: cover property (ce && bo.coll && bo.aggr);
endmodule : smc_backoff

// [hw/smc_bo_if.sv]
// Carrier between the control block and its back-off slot calculator.
// Assumes both ends share mclk; no crossing happens here.
`timescale 1ns/1ns
interface smc_bo_if;
	logic coll;
	logic [4:0] coll_cnt;
	logic alt;
	logic aggr;
	logic vld;
	logic [9:0] slots;
	modport ctl (output coll, output coll_cnt, output alt, output aggr, input vld, input slots);
	modport calc (input coll, input coll_cnt, input alt, input aggr, output vld, output slots);
endinterface : smc_bo_if

// [hw/smc_pkg.sv]
// Constants and field positions for the switch MAC control block.
// Assumes one 125 MHz clock and a byte-wide plain register port.
//
// Contract
// - Alternate back-off bit 7 acts only on half-duplex ports, never full-duplex.
// - Length check bit 3: type/length below 1500 and mismatching length discards.
// - Drop mode one: drop frame with pause type or pause address.
// - Drop mode zero: drop frame only with pause type and pause address.
// - Aggressive back-off bit 0 shortens half-duplex back-off; clear disables it.
// - No-excessive-collision-drop keeps frames at 16+ collisions; otherwise drop them.
package smc_pkg;
	// ****************************************************************
	// Register map.
	// ****************************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] OFS_CTL0 = 16'h0330;
	localparam logic [15:0] OFS_COLL = 16'h0331;
	localparam logic [15:0] OFS_STAT = 16'h0334;
	localparam logic [7:0] CTL0_RST = 8'h04;
	localparam logic [7:0] COLL_RST = 8'h00;
	localparam int CTL_ALT_BO = 7;
	localparam int CTL_LEN_CHK = 3;
	localparam int CTL_FC_MODE = 1;
	localparam int CTL_AGGR_BO = 0;
	localparam int COLL_NO_DROP = 3;
	localparam int STAT_PAUSE = 0;
	localparam int STAT_LEN = 1;
	localparam int STAT_EXCESS = 2;

	// ****************************************************************
	// Frame and back-off constants.
	// ****************************************************************
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
	localparam logic [15:0] LEN_LIMIT = 16'h05dc;
	localparam logic [4:0] EXCESS_COLL = 5'h10;
	localparam logic [3:0] STD_KMAX = 4'ha;
	localparam logic [3:0] ALT_KMAX = 4'h8;
	localparam logic [3:0] AGGR_KMAX = 4'h4;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
endpackage : smc_pkg

// [hw/smc_top.sv]
// Switch MAC control register with ingress pause and length filtering and
// half-duplex back-off control.
// Assumes all inputs come from logic on mclk and frame fields are stable while frm_vld is high.
`timescale 1ns/1ns
module smc_top (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [smc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [smc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [smc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic half_duplex,
	input wire logic frm_vld,
	input wire logic [47:0] frm_da,
	input wire logic [15:0] frm_type,
	input wire logic [15:0] frm_len,
	output logic frm_done,
	output logic frm_drop,
	input wire logic tx_coll,
	input wire logic [4:0] tx_coll_cnt,
	output logic coll_drop,
	output logic coll_keep,
	output logic alt_bo_act,
	output logic aggr_bo_act,
	output logic bo_vld,
	output logic [9:0] bo_slots
);
	import smc_pkg::*;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] coll;
		logic [2:0] stat;
		logic [7:0] rdata;
		logic done;
		logic drop;
		logic cdrop;
		logic ckeep;
		logic alt_act;
		logic aggr_act;
	} smc_state_s;

	smc_state_s s_q;
	smc_state_s s_d;
	logic type_hit;
	logic da_hit;
	logic pause_drop;
	logic len_bad;
	logic excess;
	logic no_drop;

	smc_bo_if bo ();

	// ****************************************************************
	// Decode helpers.
	// ****************************************************************

	// Pause-frame drop decision; mode one is an OR, mode zero an AND.
	function automatic logic fn_pause_drop(input logic mode, input logic t, input logic d);
		fn_pause_drop = mode ? (t | d) : (t & d);
	endfunction : fn_pause_drop

	// Read mux; unmapped addresses return zero.
	function automatic logic [7:0] fn_read(input logic [15:0] a, input smc_state_s s);
		case (a)
			OFS_CTL0: fn_read = s.ctl;
			OFS_COLL: fn_read = s.coll;
			OFS_STAT: fn_read = {5'h00, s.stat};
			default: fn_read = 8'h00;
		endcase
	endfunction : fn_read

	// ****************************************************************
	// Next state.
	// ****************************************************************

	// Frame filtering, collision policy and register access in one pass.
	always_comb begin
		s_d = s_q;
		type_hit = (frm_type == PAUSE_TYPE);
		da_hit = (frm_da == PAUSE_DA);
		pause_drop = fn_pause_drop(s_q.ctl[CTL_FC_MODE], type_hit, da_hit);
		// The check only applies to true length fields, so typed frames pass untouched.
		len_bad = s_q.ctl[CTL_LEN_CHK] && (frm_type < LEN_LIMIT) && (frm_len != frm_type);
		s_d.done = frm_vld;
		s_d.drop = frm_vld && (pause_drop || len_bad);
		if (frm_vld) begin
			s_d.stat[STAT_PAUSE] = pause_drop;
			s_d.stat[STAT_LEN] = len_bad;
		end
		no_drop = s_q.coll[COLL_NO_DROP];
		excess = tx_coll && (tx_coll_cnt >= EXCESS_COLL);
		s_d.cdrop = excess && !no_drop;
		s_d.ckeep = excess && no_drop;
		if (tx_coll) begin
			s_d.stat[STAT_EXCESS] = excess && !no_drop;
		end
		// Back-off modes never reach a full-duplex port.
		s_d.alt_act = s_q.ctl[CTL_ALT_BO] && half_duplex;
		s_d.aggr_act = s_q.ctl[CTL_AGGR_BO] && half_duplex;
		// Reserved bits store what is written; keeping them at default is up to software.
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTL0: s_d.ctl = reg_wdata;
				OFS_COLL: s_d.coll = reg_wdata;
				default: s_d.ctl = s_q.ctl;
			endcase
		end
		s_d.rdata = reg_rd ? fn_read(reg_addr, s_q) : 8'h00;
	end

	// ****************************************************************
	// State register.
	// ****************************************************************

	// Clock enable low freezes everything, including the read data.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.ctl <= CTL0_RST;
			s_q.coll <= COLL_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Back-off calculator.
	// ****************************************************************

	// Only half-duplex collisions request a back-off draw.
	assign bo.coll = tx_coll && half_duplex;
	assign bo.coll_cnt = tx_coll_cnt;
	assign bo.alt = s_q.ctl[CTL_ALT_BO];
	assign bo.aggr = s_q.ctl[CTL_AGGR_BO];

	smc_backoff u_bo (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.bo(bo)
	);

	assign reg_rdata = s_q.rdata;
	assign frm_done = s_q.done;
	assign frm_drop = s_q.drop;
	assign coll_drop = s_q.cdrop;
	assign coll_keep = s_q.ckeep;
	assign alt_bo_act = s_q.alt_act;
	assign aggr_bo_act = s_q.aggr_act;
	assign bo_vld = bo.vld;
	assign bo_slots = bo.slots;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	rst_value_a: assert property ($rose(rst_b) |-> s_q.ctl == CTL0_RST && s_q.coll == COLL_RST)
		else $error("control register reset value wrong");
	read_data_a: assert property (ce && reg_rd |=> reg_rdata == fn_read($past(reg_addr), $past(s_q)))
		else $error("read data wrong in cycle after strobe");
	read_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read slot");
	pause_or_a: assert property (ce && frm_vld && s_q.ctl[CTL_FC_MODE]
		&& (type_hit || da_hit) |=> frm_drop)
		else $error("pause frame kept in either mode");
	pause_and_a: assert property (ce && frm_vld && !s_q.ctl[CTL_FC_MODE]
		&& !s_q.ctl[CTL_LEN_CHK] && (type_hit != da_hit) |=> !frm_drop)
		else $error("half-matching pause frame dropped in both mode");
	len_off_a: assert property (ce && frm_vld && !s_q.ctl[CTL_LEN_CHK]
		&& !pause_drop |=> frm_done && !frm_drop)
		else $error("length checked while disabled");
	len_bad_a: assert property (ce && frm_vld && s_q.ctl[CTL_LEN_CHK]
		&& frm_type < LEN_LIMIT && frm_len != frm_type |=> frm_drop ##0 s_q.stat[STAT_LEN])
		else $error("length mismatch not discarded");
	// The policy bit counts as it stood at the collision edge; a write to the
	// collision control register in that same cycle only governs later collisions.
	excess_coll_a: assert property (ce && excess
		|=> coll_drop == !$past(no_drop) && coll_keep == $past(no_drop))
		else $error("excessive collision policy wrong");
	full_dup_a: assert property (ce && !half_duplex |=> !alt_bo_act && !aggr_bo_act)
		else $error("back-off mode active on full duplex");
	bo_draw_a: assert property (ce && tx_coll && half_duplex |=> bo_vld)
		else $error("half-duplex collision produced no back-off draw");

	// Frame and collision outputs are pulses: nothing shows without a request.
	frm_quiet_a: assert property (ce && !frm_vld |=> !frm_done && !frm_drop)
		else $error("frame pulse without a frame");
	pause_both_a: assert property (ce && frm_vld && type_hit && da_hit
		|=> frm_drop ##0 s_q.stat[STAT_PAUSE])
		else $error("full pause match kept");
	len_typed_a: assert property (ce && frm_vld && frm_type >= LEN_LIMIT
		&& !pause_drop |=> !frm_drop)
		else $error("typed frame length checked");
	coll_quiet_a: assert property (ce && !excess |=> !coll_drop && !coll_keep)
		else $error("collision policy pulse without excess");
	stat_excess_a: assert property (ce && excess && !no_drop
		|=> s_q.stat[STAT_EXCESS])
		else $error("excessive collision drop not recorded");
	fd_no_draw_a: assert property (ce && !(tx_coll && half_duplex) |=> !bo_vld)
		else $error("back-off draw without half-duplex collision");
	// A full-duplex collision must leave the last slot count alone.
	slots_hold_a: assert property (!(ce && tx_coll && half_duplex)
		|=> $stable(bo_slots))
		else $error("back-off slots moved without a draw");
	alt_on_a: assert property (ce && half_duplex && s_q.ctl[CTL_ALT_BO]
		|=> alt_bo_act)
		else $error("alternate back-off not active on half duplex");
	aggr_on_a: assert property (ce && half_duplex && s_q.ctl[CTL_AGGR_BO]
		|=> aggr_bo_act)
		else $error("aggressive back-off not active on half duplex");

	// Register port: writes land at their own edge; the status address is read-only.
	write_ctl_a: assert property (ce && reg_wr && reg_addr == OFS_CTL0
		|=> s_q.ctl == $past(reg_wdata))
		else $error("control write did not land");
	write_coll_a: assert property (ce && reg_wr && reg_addr == OFS_COLL
		|=> s_q.coll == $past(reg_wdata))
		else $error("collision control write did not land");
	stat_ro_a: assert property (ce && reg_wr && reg_addr == OFS_STAT
		|=> $stable(s_q.ctl) && $stable(s_q.coll))
		else $error("write to status address changed a register");
	// Clock enable low must hold every bit, read data and pulses included.
	freeze_a: assert property (!ce |=> $stable(s_q))
		else $error("state moved while clock enable low");

	cover_pause_c: cover property (ce && frm_vld && type_hit && da_hit);
	cover_len_c: cover property (ce && frm_vld && len_bad);
	cover_keep_c: cover property (ce && tx_coll && excess && no_drop);
	cover_write_c: cover property (ce && reg_wr ##1 ce && reg_rd);
endmodule : smc_top

// [test/smc_top_bench.sv]
// Self-checking bench for the switch MAC control block: registers, frame filter, back-off.
// Assumes the design package and top module are compiled first; ce is held high except in
// the one freeze test.
`timescale 1ns/1ns
module smc_top_bench;
	import smc_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic half_duplex = 1'b0;
	logic frm_vld = 1'b0;
	logic [47:0] frm_da = 48'h0000_0000_0000;
	logic [15:0] frm_type = 16'h0000;
	logic [15:0] frm_len = 16'h0000;
	logic frm_done, frm_drop, tx_coll = 1'b0, coll_drop, coll_keep;
	logic [4:0] tx_coll_cnt = 5'h00;
	logic alt_bo_act, aggr_bo_act, bo_vld;
	logic [9:0] bo_slots;
	int err_total = 0;
	int n_compared = 0;
	// A unicast address that never matches the pause address.
	localparam logic [47:0] UC_DA = 48'h0011_2233_4455;

	// ****************************************************************
	// Clock, device under test and watchdog.
	// ****************************************************************
	// Free-running 125 MHz clock.
	always #4 mclk = ~mclk;

	smc_top u_smc_top (.mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.half_duplex(half_duplex), .frm_vld(frm_vld), .frm_da(frm_da), .frm_type(frm_type),
		.frm_len(frm_len), .frm_done(frm_done), .frm_drop(frm_drop), .tx_coll(tx_coll),
		.tx_coll_cnt(tx_coll_cnt), .coll_drop(coll_drop), .coll_keep(coll_keep),
		.alt_bo_act(alt_bo_act), .aggr_bo_act(aggr_bo_act), .bo_vld(bo_vld),
		.bo_slots(bo_slots));

	// A hang counts as a mismatch and still ends in the one closing report.
	initial begin
		#200000;
		err_total++;
		final_report();
	end

	// ****************************************************************
	// Access tasks.
	// ****************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so it is sampled there.
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, e}, "register read");
	endtask : rd

	task automatic frm(input logic [47:0] da, input logic [15:0] ty, ln, input logic x);
		@(posedge mclk);
		frm_vld <= 1'b1;
		frm_da <= da;
		frm_type <= ty;
		frm_len <= ln;
		@(posedge mclk);
		frm_vld <= 1'b0;
		#1 chk({15'h0, frm_done}, 16'h0001, "frame done");
		chk({15'h0, frm_drop}, {15'h0, x}, "frame drop");
	endtask : frm

	// Checks drop, keep and draw pulses, and that the slot count stays under its cap.
	task automatic col(input logic [4:0] n, input logic hd, input logic [2:0] x, input int lim);
		@(posedge mclk);
		tx_coll <= 1'b1;
		tx_coll_cnt <= n;
		half_duplex <= hd;
		@(posedge mclk);
		tx_coll <= 1'b0;
		#1 chk({13'h0, coll_drop, coll_keep, bo_vld}, {13'h0, x}, "collision pulses");
		chk({15'h0, (int'(bo_slots) > lim)}, 16'h0000, "slot count over cap");
	endtask : col

	task automatic act(input logic hd, input logic [1:0] x);
		@(posedge mclk);
		half_duplex <= hd;
		repeat (2) @(posedge mclk);
		#1 chk({14'h0, alt_bo_act, aggr_bo_act}, {14'h0, x}, "back-off mode levels");
	endtask : act

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	// Each pass through the pause table sets every combination of type and address hit.
	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		rd(OFS_CTL0, CTL0_RST);
		rd(OFS_COLL, COLL_RST);
		wr(OFS_STAT, 8'hff);
		rd(OFS_STAT, 8'h00);
		rd(16'h0340, 8'h00);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			frm(i[1] ? PAUSE_DA : 48'h0180_c200_0002, i[0] ? PAUSE_TYPE : 16'h0800, 16'h0040,
				i[0] & i[1]);
		end
		rd(OFS_STAT, 8'h01);
		wr(OFS_CTL0, 8'h06);
		rd(OFS_CTL0, 8'h06);
		for (int i = 0; i < 4; i++) begin
			frm(i[1] ? PAUSE_DA : 48'h0180_c200_0002, i[0] ? PAUSE_TYPE : 16'h0800, 16'h0040,
				i[0] | i[1]);
		end
		$display("pause test done");
		wr(OFS_CTL0, 8'h0c);
		frm(UC_DA, 16'h0040, 16'h0041, 1'b1);
		frm(UC_DA, 16'h0040, 16'h0040, 1'b0);
		frm(UC_DA, 16'h05dc, 16'h0000, 1'b0);
		frm(UC_DA, 16'h05db, 16'h05da, 1'b1);
		rd(OFS_STAT, 8'h02);
		wr(OFS_CTL0, 8'h04);
		frm(UC_DA, 16'h0040, 16'h0041, 1'b0);
		$display("length test done");
		col(5'h10, 1'b1, 3'b101, 1023);
		col(5'h0f, 1'b1, 3'b001, 1023);
		col(5'h10, 1'b0, 3'b100, 1023);
		rd(OFS_STAT, 8'h04);
		// Alternate back-off goes on before the no-drop policy is enabled.
		wr(OFS_CTL0, 8'h84);
		wr(OFS_COLL, 8'h08);
		col(5'h1f, 1'b1, 3'b011, 1023);
		wr(OFS_CTL0, 8'h85);
		act(1'b1, 2'b11);
		col(5'h05, 1'b1, 3'b001, 15);
		wr(OFS_CTL0, 8'h84);
		act(1'b1, 2'b10);
		col(5'h09, 1'b1, 3'b001, 255);
		act(1'b0, 2'b00);
		col(5'h09, 1'b0, 3'b000, 255);
		$display("back-off test done");
		// A write made while the clock enable is low must not land.
		@(posedge mclk);
		ce <= 1'b0;
		wr(OFS_CTL0, 8'h05);
		ce <= 1'b1;
		rd(OFS_CTL0, 8'h84);
		$display("clock enable test done");
		final_report();
	end
endmodule : smc_top_bench
